/* rtl/rmc_defines.svh */
// Purpose: shared constants of the radio modem control link
// Assumes: 25 MHz system clock on both ends
// Notes: offsets, fields, reset values and timing counts
`ifndef RMC_DEFINES_SVH
`define RMC_DEFINES_SVH
// timing
`define RMC_CLK_KHZ 25000
`define RMC_SCLK_MAX_KHZ 8000
`define RMC_SCLK_MIN_HALF ((`RMC_CLK_KHZ + 2 * `RMC_SCLK_MAX_KHZ - 1) / (2 * `RMC_SCLK_MAX_KHZ))
`define RMC_SCLK_HALF 4
// serial frame: command byte then 16 data bits
`define RMC_FRAME_BITS 24
`define RMC_CMD_BITS 8
`define RMC_CMD_READ_BIT 7
// modem registers
`define RMC_MREG_CTRL 6'h07
`define RMC_MREG_STATUS 6'h08
`define RMC_MCTRL_STREAM_BIT 0
`define RMC_MCTRL_OP_LSB 1
`define RMC_MCTRL_DOZE_BIT 3
`define RMC_MCTRL_HIZ_BIT 11
`define RMC_MCTRL_RESET 16'h0800
// host registers on apb
`define RMC_HREG_CTRL 8'h00
`define RMC_HREG_CMD 8'h04
`define RMC_HREG_RXDATA 8'h08
`define RMC_HREG_STATUS 8'h0c
`define RMC_HREG_INTSTAT 8'h10
`define RMC_HREG_INTMASK 8'h14
`define RMC_HCTRL_LINK_BIT 0
`define RMC_HCTRL_RST_BIT 1
`define RMC_HCTRL_WAKE_BIT 2
`define RMC_HCTRL_OPEN_BIT 3
`define RMC_HCTRL_RESET 4'h2
`define RMC_INT_XFER_BIT 0
`define RMC_INT_MIRQ_BIT 1
`define RMC_INT_CHECK_BIT 2
`endif

/* rtl/rmc_pkg.sv */
// Purpose: types of the radio modem control link
// Assumes: nothing
// Notes: states only; numbers live in the defines header
package rmc_pkg;
	// modem operating state
	typedef enum logic [1:0] {MS_OFF, MS_IDLE, MS_DOZE, MS_BUSY} rmc_mstate_t;
	// host serial engine state
	typedef enum logic [1:0] {XS_IDLE, XS_LOW, XS_HIGH} rmc_xstate_t;
endpackage

/* rtl/rmc_link_if.sv */
// Purpose: pins between host and modem
// Assumes: an undriven pin reads low
// Notes: resolves the modem's enabled outputs to wire levels
`timescale 1ns/1ps
interface rmc_link_if;
	// host driven pins, always driven
	logic modemSerialClock;
	logic mosi;
	logic hostSlaveSelectOutN;
	logic radioOperationEnable;
	logic wakeRequest;
	logic modemResetN;
	// modem outputs, enables on all but irqN
	logic misoOut;
	logic misoOe;
	logic irqN;
	logic idleExitOut;
	logic idleExitOe;
	logic checkOkOut;
	logic checkOkOe;
	// resolved levels seen by the host
	logic misoPin;
	logic idleExitIndicator;
	logic frameCheckOkIndicator;
	// undriven pins are grounded
	assign misoPin = misoOe & misoOut;
	assign idleExitIndicator = idleExitOe & idleExitOut;
	assign frameCheckOkIndicator = checkOkOe & checkOkOut;
	// modem end
	modport device (input modemSerialClock, mosi, hostSlaveSelectOutN, radioOperationEnable, wakeRequest,
		modemResetN, output misoOut, misoOe, irqN, idleExitOut, idleExitOe, checkOkOut, checkOkOe);
	// host end
	modport host (output modemSerialClock, mosi, hostSlaveSelectOutN, radioOperationEnable, wakeRequest,
		modemResetN, input misoPin, irqN, idleExitIndicator, frameCheckOkIndicator);
endinterface

/* rtl/rmc_modem.sv */
// Purpose: modem end of the control link
// Assumes: all link inputs asynchronous to clk
// Notes: serial slave mode 0, 24-bit frames
`timescale 1ns/1ps
`include "rmc_defines.svh"
module rmc_modem import rmc_pkg::*; (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// link
	rmc_link_if.device link,
	// radio core side
	output logic opStart,
	output logic [1:0] opKind,
	input wire logic opDone,
	input wire logic frameCheckOk,
	output rmc_mstate_t modemState
);
	logic [5:0] sync1_ff; // first stages
	logic [5:0] sync2_ff; // second stages
	logic sclkPrev_ff; // edge detector
	rmc_mstate_t state_ff; // operating state
	rmc_mstate_t nxt_state;
	logic [15:0] ctrl_ff; // control register
	logic [`RMC_FRAME_BITS-1:0] inSh_ff; // receive shift
	logic [15:0] outSh_ff; // transmit shift
	logic [4:0] bitCnt_ff; // bits in frame
	logic pend_ff; // event pending
	logic rdCmd_ff; // command byte asked for a read
	logic opEnPrev_ff; // enable edge
	logic misoOut_ff, misoOe_ff, irqN_ff;
	logic idleOut_ff, idleOe_ff, checkOut_ff, checkOe_ff, checkHold_ff;
	logic opStart_ff;
	// synchronised pins
	wire sclk = sync2_ff[0];
	wire mosiS = sync2_ff[1];
	wire selN = sync2_ff[2];
	wire opEn = sync2_ff[3];
	wire wake = sync2_ff[4];
	wire resN = sync2_ff[5];
	wire rise = sclk & ~sclkPrev_ff;
	wire fall = ~sclk & sclkPrev_ff;
	wire live = (state_ff == MS_IDLE) | (state_ff == MS_BUSY); // serial accepted
	wire sel = ~selN & live; // [R16] [R15]
	wire [`RMC_FRAME_BITS-1:0] frame = {inSh_ff[`RMC_FRAME_BITS-2:0], mosiS};
	wire cmdDone = sel & rise & (bitCnt_ff == 5'(`RMC_CMD_BITS - 1));
	wire frmDone = sel & rise & (bitCnt_ff == 5'(`RMC_FRAME_BITS - 1));
	wire isRead = rdCmd_ff; // read flag held for the data phase
	wire [5:0] cmdAddr = frame[5:0];
	wire wrCtrl = frmDone & ~frame[`RMC_FRAME_BITS-1-(`RMC_CMD_BITS-1-`RMC_CMD_READ_BIT)]
		& (frame[`RMC_FRAME_BITS-3:`RMC_FRAME_BITS-8] == `RMC_MREG_CTRL);
	wire rdStat = cmdDone & frame[`RMC_CMD_READ_BIT] & (cmdAddr == `RMC_MREG_STATUS);
	wire [15:0] rdData = (cmdAddr == `RMC_MREG_CTRL) ? ctrl_ff :
		(cmdAddr == `RMC_MREG_STATUS) ? {13'h0000, pend_ff, state_ff} : 16'h0000;
	wire stream = ctrl_ff[`RMC_MCTRL_STREAM_BIT];
	wire opRise = opEn & ~opEnPrev_ff;

	// two flip-flops on every link input
	always_ff @(posedge clk) begin
		sync1_ff <= {link.modemResetN, link.wakeRequest, link.radioOperationEnable,
			link.hostSlaveSelectOutN, link.mosi, link.modemSerialClock};
		sync2_ff <= sync1_ff;
		sclkPrev_ff <= sclk;
		opEnPrev_ff <= opEn;
	end

	// state transitions
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			MS_OFF: begin
				nxt_state = MS_IDLE; // [R15]
			end
			MS_IDLE: begin
				if (wrCtrl & frame[`RMC_MCTRL_DOZE_BIT]) begin
					nxt_state = MS_DOZE;
				end else if (opRise) begin
					nxt_state = MS_BUSY; // [R10]
				end
			end
			MS_DOZE: begin
				if (wake) begin
					nxt_state = MS_IDLE; // [R06]
				end
			end
			default: begin
				if (opDone | ~opEn) begin
					nxt_state = MS_IDLE;
				end
			end
		endcase
		if (~resN) begin
			nxt_state = MS_OFF; // [R15]
		end
	end

	// state and control register
	always_ff @(posedge clk) begin
		if (rst) begin
			state_ff <= MS_OFF;
			ctrl_ff <= `RMC_MCTRL_RESET; // [R01]
		end else begin
			state_ff <= nxt_state;
			if (~resN) begin
				ctrl_ff <= `RMC_MCTRL_RESET; // [R01]
			end else if (wrCtrl) begin
				ctrl_ff <= frame[15:0] & ~(16'h0001 << `RMC_MCTRL_DOZE_BIT); // [R13]
			end
		end
	end

	// serial shifter
	always_ff @(posedge clk) begin
		if (rst | ~sel) begin
			bitCnt_ff <= 5'h00;
			inSh_ff <= '0;
			outSh_ff <= 16'h0000;
			rdCmd_ff <= 1'b0;
		end else if (rise) begin
			bitCnt_ff <= bitCnt_ff + 5'h01;
			inSh_ff <= frame;
			if (cmdDone) begin
				outSh_ff <= rdData; // [R07]
				// the shifter moves the flag on, so keep it apart
				rdCmd_ff <= frame[`RMC_CMD_READ_BIT];
			end
		end else if (fall & (bitCnt_ff >= 5'(`RMC_CMD_BITS))) begin
			outSh_ff <= {outSh_ff[14:0], 1'b0};
		end
	end

	// miso drive
	always_ff @(posedge clk) begin
		if (rst | ~sel) begin
			misoOut_ff <= 1'b0; // [R13]
		end else if (fall & (bitCnt_ff >= 5'(`RMC_CMD_BITS)) & isRead) begin
			misoOut_ff <= outSh_ff[15]; // [R07]
		end
		misoOe_ff <= ~rst & (state_ff != MS_OFF) & (sel | ~ctrl_ff[`RMC_MCTRL_HIZ_BIT]); // [R12] [R13]
	end

	// pending event and interrupt, set wins
	always_ff @(posedge clk) begin
		if (rst | (state_ff == MS_OFF)) begin
			pend_ff <= 1'b0;
			irqN_ff <= 1'b1;
		end else begin
			pend_ff <= (state_ff == MS_BUSY & opDone) | (pend_ff & ~rdStat);
			irqN_ff <= ~pend_ff; // [R09]
		end
	end

	// stream status pins and operation start
	always_ff @(posedge clk) begin
		if (rst | (state_ff == MS_OFF)) begin
			idleOe_ff <= 1'b0; // [R01]
			checkOe_ff <= 1'b0;
			idleOut_ff <= 1'b0;
			checkOut_ff <= 1'b0;
			checkHold_ff <= 1'b0;
			opStart_ff <= 1'b0;
		end else begin
			idleOe_ff <= stream; // [R05]
			checkOe_ff <= stream; // [R04]
			idleOut_ff <= state_ff == MS_BUSY; // [R05]
			if (state_ff == MS_BUSY & opDone) begin
				checkHold_ff <= frameCheckOk;
			end else if (nxt_state == MS_BUSY & state_ff != MS_BUSY) begin
				checkHold_ff <= 1'b0;
			end
			checkOut_ff <= checkHold_ff; // [R04]
			opStart_ff <= (state_ff == MS_IDLE) & (nxt_state == MS_BUSY); // [R10]
		end
	end

	assign link.misoOut = misoOut_ff;
	assign link.misoOe = misoOe_ff;
	assign link.irqN = irqN_ff;
	assign link.idleExitOut = idleOut_ff;
	assign link.idleExitOe = idleOe_ff;
	assign link.checkOkOut = checkOut_ff;
	assign link.checkOkOe = checkOe_ff;
	assign opStart = opStart_ff;
	assign opKind = ctrl_ff[`RMC_MCTRL_OP_LSB+1:`RMC_MCTRL_OP_LSB];
	assign modemState = state_ff;
endmodule // rmc_modem

/* rtl/rmc_host.sv */
// Purpose: host end of the control link with apb registers
// Assumes: modem pins asynchronous to clk
// Notes: serial master mode 0, makes the serial clock by division
`timescale 1ns/1ps
`include "rmc_defines.svh"
// Contract
// [R01] modem general pins start as inputs
// [R02] unused modem general pins read grounded
// [R03] host drives control pins during low power
// [R04] stream mode: pin two shows frame check
// [R05] stream mode: pin one shows idle exit
// [R06] host wake request wakes dozing modem
// [R07] host clocks and sends, modem returns data
// [R08] host slave select frames every transaction
// [R09] modem signals events on interrupt request
// [R10] operation enable starts transmit, receive, check
// [R11] host drives modem reset from port bit
// [R12] miso undriven while unselected by default
// [R13] cleared enable bit drives miso low instead
// [R14] host configures pins before controlling modem
// [R15] reset release moves modem to idle
// [R16] modem selected only while select held low
// [R17] serial clock never above eight megahertz
// [R18] select and enable idle during modem reset; a frame already running keeps select low to its end
module rmc_host import rmc_pkg::*; #(
	parameter int SCLK_HALF = `RMC_SCLK_HALF
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// interrupt
	output logic irq,
	// link
	rmc_link_if.host link
);
	// half period never shorter than the modem limit
	localparam int HALF = (SCLK_HALF < `RMC_SCLK_MIN_HALF) ? `RMC_SCLK_MIN_HALF : SCLK_HALF; // [R17]

	logic [3:0] sync1_ff; // first stages
	logic [3:0] sync2_ff; // second stages
	logic [3:0] ctrl_ff; // control bits
	logic [2:0] intStat_ff; // sticky events
	logic [2:0] intMask_ff; // event mask
	logic [15:0] rxData_ff; // last read data
	logic [`RMC_FRAME_BITS-1:0] txSh_ff; // outgoing frame
	logic [15:0] rxSh_ff; // incoming bits
	logic [4:0] bitCnt_ff; // bit index
	logic [7:0] halfCnt_ff; // half period count
	rmc_xstate_t xst_ff; // serial engine state
	logic xferDone_ff; // end of frame pulse
	logic irqPrev_ff, chkPrev_ff;
	logic sclk_ff, mosi_ff, ssN_ff, resN_ff, wake_ff, opEn_ff;
	logic [31:0] prdata_ff;
	logic pready_ff, pslverr_ff, irq_ff;

	// synchronised modem outputs
	wire misoS = sync2_ff[0];
	wire mirqN = sync2_ff[1];
	wire idleS = sync2_ff[2];
	wire chkS = sync2_ff[3];
	// apb decode
	wire access = psel & penable & pready_ff;
	wire wrEn = access & pwrite;
	wire hitCtrl = paddr == `RMC_HREG_CTRL;
	wire hitCmd = paddr == `RMC_HREG_CMD;
	wire hitRx = paddr == `RMC_HREG_RXDATA;
	wire hitStat = paddr == `RMC_HREG_STATUS;
	wire hitIs = paddr == `RMC_HREG_INTSTAT;
	wire hitIm = paddr == `RMC_HREG_INTMASK;
	wire mapped = hitCtrl | hitCmd | hitRx | hitStat | hitIs | hitIm;
	wire [31:0] rdMux = hitCtrl ? {28'h0000000, ctrl_ff} :
		hitRx ? {16'h0000, rxData_ff} :
		hitStat ? {28'h0000000, chkS, idleS, ~mirqN, xst_ff != XS_IDLE} :
		hitIs ? {29'h00000000, intStat_ff} :
		hitIm ? {29'h00000000, intMask_ff} : 32'h00000000;
	// control bits
	wire linkEn = ctrl_ff[`RMC_HCTRL_LINK_BIT];
	wire holdRst = ctrl_ff[`RMC_HCTRL_RST_BIT] | ~linkEn; // [R14] [R11]
	wire start = wrEn & hitCmd & (xst_ff == XS_IDLE) & ~holdRst; // [R18]
	wire halfUp = halfCnt_ff == 8'(HALF - 1);
	wire lastBit = bitCnt_ff == 5'(`RMC_FRAME_BITS - 1);
	// events
	wire [2:0] events = {chkS & ~chkPrev_ff, ~mirqN & irqPrev_ff, xferDone_ff};

	// two flip-flops on every modem output
	always_ff @(posedge clk) begin
		sync1_ff <= {link.frameCheckOkIndicator, link.idleExitIndicator, link.irqN, link.misoPin}; // [R02]
		sync2_ff <= sync1_ff;
		irqPrev_ff <= mirqN;
		chkPrev_ff <= chkS;
	end

	// apb slave: no wait cycle, answer from flip-flops
	always_ff @(posedge clk) begin
		if (rst) begin
			pready_ff <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff <= 32'h00000000;
		end else begin
			pready_ff <= psel & ~penable & ~pready_ff;
			pslverr_ff <= psel & ~penable & ~mapped;
			prdata_ff <= (psel & ~penable & ~pwrite) ? rdMux : 32'h00000000;
		end
	end

	// control, mask and sticky status
	always_ff @(posedge clk) begin
		if (rst) begin
			ctrl_ff <= `RMC_HCTRL_RESET; // [R11]
			intMask_ff <= 3'h0;
			intStat_ff <= 3'h0;
		end else begin
			if (wrEn & hitCtrl) begin
				ctrl_ff <= pwdata[3:0];
			end
			if (wrEn & hitIm) begin
				intMask_ff <= pwdata[2:0];
			end
			// set wins over a write-one clear
			intStat_ff <= events | (intStat_ff & ~((wrEn & hitIs) ? pwdata[2:0] : 3'h0)); // [R09]
		end
	end

	// pins driven from flip-flops at all times
	always_ff @(posedge clk) begin
		if (rst) begin
			resN_ff <= 1'b0;
			wake_ff <= 1'b0;
			opEn_ff <= 1'b0;
			irq_ff <= 1'b0;
		end else begin
			resN_ff <= ~holdRst; // [R11]
			wake_ff <= ~holdRst & ctrl_ff[`RMC_HCTRL_WAKE_BIT]; // [R06] [R03]
			opEn_ff <= ~holdRst & ctrl_ff[`RMC_HCTRL_OPEN_BIT]; // [R10] [R18]
			irq_ff <= |(intStat_ff & intMask_ff);
		end
	end

	// serial engine
	always_ff @(posedge clk) begin
		if (rst) begin
			xst_ff <= XS_IDLE;
			sclk_ff <= 1'b0;
			mosi_ff <= 1'b0;
			ssN_ff <= 1'b1;
			bitCnt_ff <= 5'h00;
			halfCnt_ff <= 8'h00;
			txSh_ff <= '0;
			rxSh_ff <= 16'h0000;
			rxData_ff <= 16'h0000;
			xferDone_ff <= 1'b0;
		end else begin
			xferDone_ff <= 1'b0;
			halfCnt_ff <= halfUp ? 8'h00 : halfCnt_ff + 8'h01;
			case (xst_ff)
				XS_IDLE: begin
					ssN_ff <= 1'b1; // [R18] [R03]
					sclk_ff <= 1'b0;
					if (start) begin
						xst_ff <= XS_LOW;
						ssN_ff <= 1'b0; // [R08] [R16]
						txSh_ff <= {pwdata[`RMC_FRAME_BITS-2:0], 1'b0};
						mosi_ff <= pwdata[`RMC_FRAME_BITS-1]; // [R07]
						bitCnt_ff <= 5'h00;
						halfCnt_ff <= 8'h00;
					end
				end
				XS_LOW: begin
					if (halfUp) begin
						sclk_ff <= 1'b1; // [R07] [R17]
						xst_ff <= XS_HIGH;
					end
				end
				default: begin
					if (halfUp) begin
						sclk_ff <= 1'b0;
						rxSh_ff <= {rxSh_ff[14:0], misoS}; // [R07]
						if (lastBit) begin
							xst_ff <= XS_IDLE;
							ssN_ff <= 1'b1; // [R08]
							mosi_ff <= 1'b0;
							rxData_ff <= {rxSh_ff[14:0], misoS};
							xferDone_ff <= 1'b1;
						end else begin
							xst_ff <= XS_LOW;
							bitCnt_ff <= bitCnt_ff + 5'h01;
							mosi_ff <= txSh_ff[`RMC_FRAME_BITS-1];
							txSh_ff <= {txSh_ff[`RMC_FRAME_BITS-2:0], 1'b0};
						end
					end
				end
			endcase
		end
	end

	assign link.modemSerialClock = sclk_ff;
	assign link.mosi = mosi_ff;
	assign link.hostSlaveSelectOutN = ssN_ff;
	assign link.radioOperationEnable = opEn_ff;
	assign link.wakeRequest = wake_ff;
	assign link.modemResetN = resN_ff;
	assign prdata = prdata_ff;
	assign pready = pready_ff;
	assign pslverr = pslverr_ff;
	assign irq = irq_ff;
endmodule // rmc_host

/* test/rmc_link_assertions.sv */
// Purpose: pin checks between host and modem
// Assumes: one clock for both ends
// Notes: watches interface signals as plain inputs
`timescale 1ns/1ps
module rmc_link_assertions #(
	parameter int SCLK_HALF = 4
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// host driven pins
	input wire logic modemSerialClock,
	input wire logic mosi,
	input wire logic hostSlaveSelectOutN,
	input wire logic radioOperationEnable,
	input wire logic modemResetN,
	// modem driven pins
	input wire logic misoOe,
	input wire logic irqN,
	input wire logic idleExitOe,
	input wire logic checkOkOe,
	input wire logic idleExitIndicator
);
	logic sclkQ_ff; // last clock level
	logic [7:0] runLen_ff; // cycles of that level
	logic [5:0] riseCnt_ff; // rises in frame
	logic sclkRise; // rise seen now
	logic [7:0] nxt_runLen;
	assign sclkRise = modemSerialClock & ~sclkQ_ff;
	assign nxt_runLen = (runLen_ff == 8'hff) ? runLen_ff : runLen_ff + 8'h01;
	// track clock levels and rises
	always_ff @(posedge clk) begin
		if (rst) begin
			sclkQ_ff <= 1'b0;
			runLen_ff <= 8'h01;
			riseCnt_ff <= 6'h00;
		end else begin
			sclkQ_ff <= modemSerialClock;
			runLen_ff <= (modemSerialClock != sclkQ_ff) ? 8'h01 : nxt_runLen;
			riseCnt_ff <= hostSlaveSelectOutN ? 6'h00 : riseCnt_ff + {5'h00, sclkRise};
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	a_sclk_idle_unsel: assert property (hostSlaveSelectOutN |-> !modemSerialClock)
		else $error("serial clock high while unselected");
	a_reset_pins_safe: assert property (!modemResetN |-> hostSlaveSelectOutN && !radioOperationEnable)
		else $error("select or enable active during modem reset");
	a_off_pins_quiet: assert property ((!modemResetN && !$past(modemResetN, 6))
		|-> !misoOe && !idleExitOe && !checkOkOe && irqN)
		else $error("modem drives pins while held in reset");
	a_miso_when_sel: assert property ((!hostSlaveSelectOutN && modemResetN)[*6] |-> misoOe)
		else $error("miso undriven while selected");
	a_frame_bit_count: assert property ($rose(hostSlaveSelectOutN) |-> riseCnt_ff == 6'h18)
		else $error("frame clock rise count wrong");
	a_sclk_half_len: assert property ((modemSerialClock != sclkQ_ff) |-> int'(runLen_ff) >= SCLK_HALF)
		else $error("serial clock half too short");
	a_mosi_hold_high: assert property (modemSerialClock && sclkQ_ff |-> $stable(mosi))
		else $error("mosi moved while clock high");
	a_sel_end_fall: assert property ($rose(hostSlaveSelectOutN) |-> !modemSerialClock && sclkQ_ff)
		else $error("select released off a clock fall");
	cover property ($rose(hostSlaveSelectOutN));
	cover property ($fell(irqN));
	cover property ($rose(idleExitIndicator));
endmodule // rmc_link_assertions

/* test/rmc_tb.sv */
// Purpose: self-checking bench for host and modem ends
// Assumes: 25 MHz shared clock
// Notes: reset pin checks first, then register rows, then link cases
`timescale 1ns/1ps
`include "rmc_defines.svh"
module rmc_tb import rmc_pkg::*; ();
	typedef struct packed {logic w; logic [7:0] a; logic [31:0] d; logic [31:0] exp; logic err;} rmc_row_t;
	logic clk, rst, psel, penable, pwrite, pready, pslverr, irq, opStart, opDone, frameCheckOk, er;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [1:0] opKind;
	rmc_mstate_t modemState;
	int bad_count, num_checks, cycles, i, k;
	// register rows: write, addr, data, read value, error
	rmc_row_t rows [7] = '{'{1'b0, `RMC_HREG_CTRL, 32'h0, 32'h2, 1'b0}, '{1'b1, `RMC_HREG_CTRL, 32'h1, 32'h0, 1'b0},
		'{1'b0, `RMC_HREG_CTRL, 32'h0, 32'h1, 1'b0}, '{1'b1, `RMC_HREG_INTMASK, 32'h7, 32'h0, 1'b0},
		'{1'b0, `RMC_HREG_INTMASK, 32'h0, 32'h7, 1'b0}, '{1'b0, 8'h18, 32'h0, 32'h0, 1'b1},
		'{1'b1, 8'h1c, 32'h5, 32'h0, 1'b1}};
	rmc_link_if linkBus();
	rmc_host #(.SCLK_HALF(4)) rmc_host_inst (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .irq(irq), .link(linkBus));
	rmc_modem rmc_modem_inst (.clk(clk), .rst(rst), .link(linkBus), .opStart(opStart), .opKind(opKind),
		.opDone(opDone), .frameCheckOk(frameCheckOk), .modemState(modemState));
	rmc_link_assertions #(.SCLK_HALF(4)) rmc_link_assertions_inst (.clk(clk), .rst(rst),
		.modemSerialClock(linkBus.modemSerialClock), .mosi(linkBus.mosi),
		.hostSlaveSelectOutN(linkBus.hostSlaveSelectOutN), .radioOperationEnable(linkBus.radioOperationEnable),
		.modemResetN(linkBus.modemResetN), .misoOe(linkBus.misoOe), .irqN(linkBus.irqN),
		.idleExitOe(linkBus.idleExitOe), .checkOkOe(linkBus.checkOkOe),
		.idleExitIndicator(linkBus.idleExitIndicator));
	// 40 ns clock
	always #20 clk = ~clk;
	// compare and count
	task chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// verdict and stop
	task finish_test;
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// one apb transfer, result in rd and er
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		// wait for pready; the hang guard bounds this
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// serial frame through the host, received word left in rd
	task xfer(input logic [23:0] f);
		apb(1'b1, `RMC_HREG_CMD, {8'h00, f});
		// a frame outlasts many polls; the hang guard bounds this
		do begin
			apb(1'b0, `RMC_HREG_STATUS, 32'h0);
		end while (rd[0] !== 1'b0);
		apb(1'b0, `RMC_HREG_INTSTAT, 32'h0);
		chk(rd[0], 1'b1);
		apb(1'b1, `RMC_HREG_INTSTAT, 32'h1);
		apb(1'b0, `RMC_HREG_RXDATA, 32'h0);
	endtask
	// bounded wait for a modem state
	task waitState(input rmc_mstate_t s);
		int n;
		for (n = 0; n < 20; n++) begin
			@(negedge clk);
			if (modemState === s) break;
		end
		chk(modemState, s);
	endtask
	// hang guard
	always @(posedge clk) begin
		cycles++;
		if (cycles == 30000) begin
			bad_count++;
			finish_test;
		end
	end
	// main sequence
	initial begin
		clk = 0;
		rst = 1;
		psel = 0;
		penable = 0;
		pwrite = 0;
		paddr = 0;
		pwdata = 0;
		opDone = 0;
		frameCheckOk = 0;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		@(negedge clk);
		chk({linkBus.modemResetN, linkBus.hostSlaveSelectOutN}, 2'b01);
		chk(modemState, MS_OFF);
		chk({linkBus.misoOe, linkBus.idleExitOe, linkBus.checkOkOe}, 3'h0);
		chk(linkBus.frameCheckOkIndicator, 1'b0);
		// register rows
		for (i = 0; i < 7; i++) begin
			apb(rows[i].w, rows[i].a, rows[i].d);
			if (!rows[i].w) chk(rd, rows[i].exp);
			chk(er, rows[i].err);
		end
		waitState(MS_IDLE);
		chk(linkBus.misoOe, 1'b0);
		xfer({8'h07, 16'h0001});
		repeat (8) @(negedge clk);
		chk({linkBus.misoOe, linkBus.misoPin}, 2'b10);
		xfer({8'h88, 16'h0000});
		chk(rd[15:0], 16'h0001);
		// each operation kind, last one masked
		for (k = 0; k < 3; k++) begin
			xfer({8'h07, 13'h0, k[1:0], 1'b1});
			apb(1'b1, `RMC_HREG_INTMASK, (k == 2) ? 32'h0 : 32'h7);
			apb(1'b1, `RMC_HREG_CTRL, 32'h9);
			for (i = 0; i < 20; i++) begin
				@(negedge clk);
				if (opStart === 1'b1) break;
			end
			chk(opStart, 1'b1);
			chk(opKind, k[1:0]);
			repeat (4) @(negedge clk);
			chk({modemState, linkBus.idleExitIndicator}, {MS_BUSY, 1'b1});
			@(posedge clk);
			opDone <= 1'b1;
			frameCheckOk <= (k != 1);
			@(posedge clk);
			opDone <= 1'b0;
			repeat (8) @(negedge clk);
			chk({linkBus.frameCheckOkIndicator, linkBus.idleExitIndicator}, {k != 1, 1'b0});
			chk({linkBus.irqN, irq}, {1'b0, k != 2});
			apb(1'b0, `RMC_HREG_INTSTAT, 32'h0);
			chk(rd, {29'h0, k != 1, 2'b10});
			apb(1'b1, `RMC_HREG_CTRL, 32'h1);
			xfer({8'h88, 16'h0000});
			chk({rd[15:0], linkBus.irqN}, {16'h0005, 1'b1});
			apb(1'b1, `RMC_HREG_INTSTAT, 32'h6);
			// irq follows the status bits one cycle later
			repeat (2) @(negedge clk);
			chk(irq, 1'b0);
		end
		// doze then wake
		xfer({8'h07, 16'h0009});
		chk(modemState, MS_DOZE);
		apb(1'b1, `RMC_HREG_CTRL, 32'h5);
		waitState(MS_IDLE);
		chk(linkBus.wakeRequest, 1'b1);
		// modem reset in mid-run
		apb(1'b1, `RMC_HREG_CTRL, 32'h3);
		repeat (10) @(negedge clk);
		chk(modemState, MS_OFF);
		chk({linkBus.modemResetN, linkBus.misoOe, linkBus.idleExitOe}, 3'h0);
		finish_test;
	end
endmodule // rmc_tb
